/* File: src/ahb_reg_slave.sv */
// Purpose: AHB-Lite address/data phase tracking for the register window
// Assumes: Single word transfers; zero wait states
// Notes:   Read select is combinational so the parent can register hrdata
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             rdReq,
  output logic [7:0]       rdAddr,
  output logic             wrEn,
  output logic [7:0]       wrAddr
);
  logic       active;
  logic       wrPend_q;
  logic [7:0] wrAddr_q;

  // NONSEQ and SEQ both have htrans[1] set
  assign active = hsel && htrans[1] && hready;
  assign rdReq  = active && !hwrite;
  assign rdAddr = haddr[7:0];
  assign wrEn   = wrPend_q;
  assign wrAddr = wrAddr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else if (hready) begin
      wrPend_q <= active && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end
endmodule
`default_nettype wire

/* File: src/cond_status_move_unit.sv */
// Purpose: Executes condition-field and status-register move instructions
// Assumes: Pipeline supplies one instruction word per insnValid pulse with operand data
// Notes:   Results appear one cycle after issue; state words are also on AHB-Lite
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cond_status_move_unit (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // AHB-Lite register window
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pipeline issue side
  input  wire logic        insnValid,
  input  wire logic [31:0] insnWord,
  input  wire logic [31:0] gprSrcData,
  input  wire logic [31:0] gprMaskData,
  input  wire logic [31:0] gprOldData,
  // Pipeline writeback side
  output logic             gprWrEn,
  output logic [4:0]       gprWrIdx,
  output logic [31:0]      gprWrData,
  output logic             fprWrEn,
  output logic [4:0]       fprWrIdx,
  output logic [63:0]      fprWrData,
  output logic             privTrap,
  output logic             illegalInsn,
  output logic             insnDone
);
  import cond_status_pkg::*;

  function automatic logic [3:0] getField(input logic [31:0] word, input logic [2:0] idx);
    getField = word[(5'd28 - {idx, 2'b00}) +: 4];
  endfunction

  function automatic logic [31:0] putField(input logic [31:0] word, input logic [2:0] idx,
                                           input logic [3:0] nib);
    logic [31:0] res;
    res = word;
    res[(5'd28 - {idx, 2'b00}) +: 4] = nib;
    putField = res;
  endfunction

  function automatic logic [31:0] stickyMask(input logic [2:0] idx);
    case (idx)
      3'h0:    stickyMask = STICKY_F0;
      3'h1:    stickyMask = STICKY_F1;
      3'h2:    stickyMask = STICKY_F2;
      3'h3:    stickyMask = STICKY_F3;
      default: stickyMask = 32'h00000000;
    endcase
  endfunction

  // Reset release through two flops
  logic [1:0] rstSync_q;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rst_n = rstSync_q[1];

  // Decode
  op_e        op;
  logic [2:0] dstField;
  logic [2:0] srcField;
  logic [4:0] tgtIdx;
  logic [4:0] raIdx;
  logic       recordBit;

  insn_decode u_decode (
    .insnWord  (insnWord),
    .op        (op),
    .dstField  (dstField),
    .srcField  (srcField),
    .tgtIdx    (tgtIdx),
    .raIdx     (raIdx),
    .recordBit (recordBit)
  );

  // Bus slave
  logic       rdReq;
  logic [7:0] rdAddr;
  logic       wrEn;
  logic [7:0] wrAddr;

  ahb_reg_slave u_bus (
    .clk    (ref_clk),
    .rst_n  (rst_n),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hready (hready),
    .rdReq  (rdReq),
    .rdAddr (rdAddr),
    .wrEn   (wrEn),
    .wrAddr (wrAddr)
  );

  // Architectural state
  logic [31:0] cr_q;
  logic [31:0] fstat_q;
  logic [31:0] xer_q;
  logic [31:0] msr_q;
  logic        newArch_q;
  logic        lastTrap_q;
  logic        lastIll_q;
  logic [15:0] execCount_q;

  // Execution results
  logic [31:0] cr_d;
  logic [31:0] fstat_d;
  logic [31:0] xer_d;
  logic        gprWr_d;
  logic [4:0]  gprIdx_d;
  logic [31:0] gprData_d;
  logic        fprWr_d;
  logic [63:0] fprData_d;
  logic        trap_d;
  logic        ill_d;
  logic [31:0] fsClean;
  logic [31:0] maskRes;
  logic        userState;

  assign fsClean   = fstat_q & ~FSTAT_RSVD;
  assign maskRes   = (gprSrcData & gprMaskData) | (gprOldData & ~gprMaskData);
  assign userState = msr_q[MSR_PR_POS];

  always_comb begin
    cr_d      = cr_q;
    fstat_d   = fstat_q;
    xer_d     = xer_q;
    gprWr_d   = 1'b0;
    gprIdx_d  = tgtIdx;
    gprData_d = 32'h00000000;
    fprWr_d   = 1'b0;
    fprData_d = 64'h0000000000000000;
    trap_d    = 1'b0;
    ill_d     = 1'b0;
    if (insnValid) begin
      case (op)
        OP_CRCOPY: begin
          // Only the destination nibble moves; exception word untouched
          cr_d = putField(cr_q, dstField, getField(cr_q, srcField));
        end
        OP_FSCOPY: begin
          cr_d    = putField(cr_q, dstField, getField(fsClean, srcField));
          fstat_d = fstat_q & ~stickyMask(srcField);
        end
        OP_XECOPY: begin
          cr_d  = putField(cr_q, dstField, xer_q[31:28]);
          xer_d = xer_q & ~XER_FLAGS;
        end
        OP_CRREAD: begin
          gprWr_d   = 1'b1;
          gprData_d = cr_q;
        end
        OP_FSREAD: begin
          fprWr_d   = 1'b1;
          fprData_d = {FPR_UPPER_FILL, fstat_q};
          if (recordBit) begin
            cr_d = putField(cr_q, 3'h1, fstat_q[31:28]);
          end
        end
        OP_MSREAD: begin
          if (newArch_q && userState) begin
            trap_d = 1'b1;
          end else begin
            gprWr_d   = 1'b1;
            gprData_d = msr_q;
          end
        end
        OP_MASKIN: begin
          gprWr_d   = 1'b1;
          gprIdx_d  = raIdx;
          gprData_d = maskRes;
          if (recordBit) begin
            cr_d = putField(cr_q, 3'h0, {maskRes[31], !maskRes[31] && (|maskRes),
                                         ~(|maskRes), xer_q[XER_SO_POS]});
          end
        end
        default: begin
          ill_d = 1'b1;
        end
      endcase
    end
  end

  // A bus write to a state word other than the status word wins over an instruction result that cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cr_q <= RST_CR;
    end else if (wrEn && wrAddr == OFS_CR) begin
      cr_q <= hwdata;
    end else begin
      cr_q <= cr_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fstat_q <= RST_FSTAT;
    end else if (wrEn && wrAddr == OFS_FSTAT) begin
      fstat_q <= hwdata;
    end else begin
      fstat_q <= fstat_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xer_q <= RST_XER;
    end else if (wrEn && wrAddr == OFS_XER) begin
      xer_q <= hwdata;
    end else begin
      xer_q <= xer_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msr_q <= RST_MSR;
    end else if (wrEn && wrAddr == OFS_MSR) begin
      msr_q <= hwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      newArch_q <= RST_NEWARCH;
    end else if (wrEn && wrAddr == OFS_CTRL) begin
      newArch_q <= hwdata[CTRL_NEWARCH_POS];
    end
  end

  // Status flags follow the last instruction; a bus write clears them unless an instruction issues that cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastTrap_q  <= 1'b0;
      lastIll_q   <= 1'b0;
      execCount_q <= 16'h0000;
    end else begin
      if (insnValid) begin
        lastTrap_q  <= trap_d;
        lastIll_q   <= ill_d;
        execCount_q <= execCount_q + 16'h0001;
      end else if (wrEn && wrAddr == OFS_STATUS) begin
        lastTrap_q  <= 1'b0;
        lastIll_q   <= 1'b0;
        execCount_q <= 16'h0000;
      end
    end
  end

  // Writeback outputs, one cycle after issue
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gprWrEn     <= 1'b0;
      gprWrIdx    <= 5'h00;
      gprWrData   <= 32'h00000000;
      fprWrEn     <= 1'b0;
      fprWrIdx    <= 5'h00;
      fprWrData   <= 64'h0000000000000000;
      privTrap    <= 1'b0;
      illegalInsn <= 1'b0;
      insnDone    <= 1'b0;
    end else begin
      gprWrEn     <= gprWr_d;
      gprWrIdx    <= gprIdx_d;
      gprWrData   <= gprData_d;
      fprWrEn     <= fprWr_d;
      fprWrIdx    <= tgtIdx;
      fprWrData   <= fprData_d;
      privTrap    <= trap_d;
      illegalInsn <= ill_d;
      insnDone    <= insnValid;
    end
  end

  // Bus read data is sampled in the address phase and stands through the data phase
  logic [31:0] rdMux;

  always_comb begin
    case (rdAddr)
      OFS_CR:     rdMux = cr_q;
      OFS_FSTAT:  rdMux = fstat_q;
      OFS_XER:    rdMux = xer_q;
      OFS_MSR:    rdMux = msr_q;
      OFS_CTRL:   rdMux = {31'h00000000, newArch_q};
      OFS_STATUS: rdMux = {execCount_q, 14'h0000, lastIll_q, lastTrap_q};
      default:    rdMux = 32'h00000000;
    endcase
    // A read right behind a write to the same word lands before that write; forward it
    if (wrEn && wrAddr == rdAddr) begin
      case (rdAddr)
        OFS_CR, OFS_FSTAT, OFS_XER, OFS_MSR: rdMux = hwdata;
        OFS_CTRL:   rdMux = {31'h00000000, hwdata[CTRL_NEWARCH_POS]};
        OFS_STATUS: begin
          // An instruction in the same cycle beats the clear
          if (!insnValid) begin
            rdMux = 32'h00000000;
          end
        end
        default:    ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rdReq) begin
        hrdata <= rdMux;
      end
    end
  end

endmodule
`default_nettype wire

/* File: src/cond_status_pkg.sv */
// Purpose: Shared constants for the condition/status move unit
// Assumes: Instruction bit 0 is the word MSB, so field bits a..b sit at [31-a:31-b]
// Notes:   Register offsets are AHB-Lite byte addresses
package cond_status_pkg;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_CRCOPY = 3'b001,
    OP_FSCOPY = 3'b010,
    OP_XECOPY = 3'b011,
    OP_CRREAD = 3'b100,
    OP_FSREAD = 3'b101,
    OP_MSREAD = 3'b110,
    OP_MASKIN = 3'b111
  } op_e;

  localparam logic [5:0] PRI_CRLOGIC = 6'h13;
  localparam logic [5:0] PRI_FIXED   = 6'h1f;
  localparam logic [5:0] PRI_FLOAT   = 6'h3f;

  localparam logic [9:0] XO_CRCOPY = 10'h000;
  localparam logic [9:0] XO_FSCOPY = 10'h040;
  localparam logic [9:0] XO_XECOPY = 10'h200;
  localparam logic [9:0] XO_CRREAD = 10'h013;
  localparam logic [9:0] XO_FSREAD = 10'h247;
  localparam logic [9:0] XO_MSREAD = 10'h053;
  localparam logic [9:0] XO_MASKIN = 10'h21d;

  localparam int OPC_LSB  = 26;
  localparam int DST_LSB  = 23;
  localparam int SRC_LSB  = 18;
  localparam int TGT_LSB  = 21;
  localparam int RA_LSB   = 16;
  localparam int RB_LSB   = 11;
  localparam int XO_LSB   = 1;
  localparam int REC_POS  = 0;

  localparam logic [7:0] OFS_CR     = 8'h00;
  localparam logic [7:0] OFS_FSTAT  = 8'h04;
  localparam logic [7:0] OFS_XER    = 8'h08;
  localparam logic [7:0] OFS_MSR    = 8'h0c;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam logic [31:0] RST_CR    = 32'h00000000;
  localparam logic [31:0] RST_FSTAT = 32'h00000000;
  localparam logic [31:0] RST_XER   = 32'h00000000;
  localparam logic [31:0] RST_MSR   = 32'h00000000;
  localparam logic        RST_NEWARCH = 1'b1;

  localparam int CTRL_NEWARCH_POS = 0;
  localparam int STAT_TRAP_POS    = 0;
  localparam int STAT_ILL_POS     = 1;
  localparam int STAT_CNT_LSB     = 16;

  // User-state bit of the machine state word (big-endian bit 17)
  localparam int MSR_PR_POS = 14;
  // Exception flag nibble of the fixed-point exception word, summary overflow at top
  localparam logic [31:0] XER_FLAGS = 32'hf0000000;
  localparam int          XER_SO_POS = 31;
  // Reserved status bit 20 reads as zero when copied
  localparam logic [31:0] FSTAT_RSVD = 32'h00000800;
  localparam logic [31:0] STICKY_F0  = 32'h90000000;
  localparam logic [31:0] STICKY_F1  = 32'h0f000000;
  localparam logic [31:0] STICKY_F2  = 32'h00f00000;
  localparam logic [31:0] STICKY_F3  = 32'h00080000;
  localparam logic [31:0] FPR_UPPER_FILL = 32'hffffffff;

endpackage

/* File: src/insn_decode.sv */
// Purpose: Combinational decode of the status-move instruction group
// Assumes: insnWord is stable while insnValid is high
// Notes:   Unknown words decode to OP_NONE
`timescale 1ns/1ps
`default_nettype none
module insn_decode (
  input  wire logic [31:0]     insnWord,
  output cond_status_pkg::op_e op,
  output logic [2:0]           dstField,
  output logic [2:0]           srcField,
  output logic [4:0]           tgtIdx,
  output logic [4:0]           raIdx,
  output logic                 recordBit
);
  import cond_status_pkg::*;

  logic [5:0] primary;
  logic [9:0] extended;

  assign primary   = insnWord[OPC_LSB +: 6];
  assign extended  = insnWord[XO_LSB +: 10];
  assign dstField  = insnWord[DST_LSB +: 3];
  assign srcField  = insnWord[SRC_LSB +: 3];
  assign tgtIdx    = insnWord[TGT_LSB +: 5];
  assign raIdx     = insnWord[RA_LSB +: 5];
  assign recordBit = insnWord[REC_POS];

  always_comb begin
    op = OP_NONE;
    if (primary == PRI_CRLOGIC && extended == XO_CRCOPY) begin
      op = OP_CRCOPY;
    end else if (primary == PRI_FLOAT) begin
      if (extended == XO_FSCOPY) begin
        op = OP_FSCOPY;
      end else if (extended == XO_FSREAD) begin
        op = OP_FSREAD;
      end
    end else if (primary == PRI_FIXED) begin
      case (extended)
        XO_XECOPY: op = OP_XECOPY;
        XO_CRREAD: op = OP_CRREAD;
        XO_MSREAD: op = OP_MSREAD;
        XO_MASKIN: op = OP_MASKIN;
        default:   op = OP_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verif/cond_status_sva.sv */
// Purpose: Port checks for the status move unit
// Assumes: The answer comes one edge after a word is taken
// Notes:   Opcodes are spelled out so a wrong package constant still shows up
`timescale 1ns/1ps
`default_nettype none
module cond_status_sva (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        insnValid,
  input wire logic [31:0] insnWord,
  input wire logic [31:0] gprSrcData,
  input wire logic [31:0] gprMaskData,
  input wire logic [31:0] gprOldData,
  input wire logic        gprWrEn,
  input wire logic [4:0]  gprWrIdx,
  input wire logic [31:0] gprWrData,
  input wire logic        fprWrEn,
  input wire logic [4:0]  fprWrIdx,
  input wire logic [63:0] fprWrData,
  input wire logic        privTrap,
  input wire logic        illegalInsn,
  input wire logic        insnDone
);
  logic [5:0]  pri;
  logic [9:0]  xo;
  logic [31:0] wordQ;
  logic        isCopy;
  logic        isMs;
  assign pri    = insnWord[31:26];
  assign xo     = insnWord[10:1];
  assign isMs   = insnValid && pri == 6'h1f && xo == 10'h053;
  assign isCopy = insnValid && ((pri == 6'h13 && xo == 10'h000)
                  || (pri == 6'h3f && xo == 10'h040) || (pri == 6'h1f && xo == 10'h200));
  // Word of the cycle before, so results can be tied to their cause
  always_ff @(posedge ref_clk) wordQ <= insnWord;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_gpr_wb;
    gprWrEn && !fprWrEn && gprWrIdx == wordQ[25:21];
  endsequence
  sequence s_fpr_wb;
    fprWrEn && !gprWrEn && fprWrIdx == wordQ[25:21] && fprWrData[63:32] == 32'hffffffff;
  endsequence
  a_done_pulse: assert property (insnValid |=> insnDone)
    else $error("no done after issue");
  a_idle_quiet: assert property (
    !insnValid |=> !insnDone && !gprWrEn && !fprWrEn && !privTrap)
    else $error("output pulse without issue");
  a_copy_no_write: assert property (
    isCopy |=> !gprWrEn && !fprWrEn && !illegalInsn)
    else $error("field copy wrote a register");
  a_cr_read: assert property (insnValid && pri == 6'h1f && xo == 10'h013 |=> s_gpr_wb)
    else $error("condition read writeback wrong");
  a_fs_read: assert property (
    insnValid && pri == 6'h3f && xo == 10'h247 |=> s_fpr_wb)
    else $error("status read writeback wrong");
  a_ms_read: assert property (isMs |=> (privTrap && !gprWrEn) or s_gpr_wb)
    else $error("machine read neither trapped nor wrote");
  a_trap_cause: assert property (
    privTrap |-> $past(insnValid) && wordQ[31:26] == 6'h1f && wordQ[10:1] == 10'h053)
    else $error("trap without machine read");
  a_mask_insert: assert property (
    insnValid && pri == 6'h1f && xo == 10'h21d |=> gprWrEn && gprWrIdx == wordQ[20:16]
      && gprWrData == (($past(gprSrcData) & $past(gprMaskData))
      | ($past(gprOldData) & ~$past(gprMaskData))))
    else $error("mask insert result wrong");
  a_illegal_word: assert property (
    insnValid && !(pri inside {6'h13, 6'h1f, 6'h3f}) |=> illegalInsn && !gprWrEn && !fprWrEn)
    else $error("foreign word not refused");
endmodule
bind cond_status_move_unit cond_status_sva CHK (
  .ref_clk, .arst_n, .insnValid, .insnWord, .gprSrcData, .gprMaskData, .gprOldData,
  .gprWrEn, .gprWrIdx, .gprWrData, .fprWrEn, .fprWrIdx, .fprWrData, .privTrap,
  .illegalInsn, .insnDone);
`default_nettype wire

/* File: verif/pipe_model.sv */
// Purpose: Pipeline stand-in issuing words and catching writeback
// Assumes: Writeback lands one edge after the word is taken
// Notes:   Released operand lines carry inverted data, never stale values
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
  input  wire logic        ref_clk,
  output logic             insnValid,
  output logic [31:0]      insnWord,
  output logic [31:0]      gprSrcData,
  output logic [31:0]      gprMaskData,
  output logic [31:0]      gprOldData,
  input  wire logic        gprWrEn,
  input  wire logic [4:0]  gprWrIdx,
  input  wire logic [31:0] gprWrData,
  input  wire logic [63:0] fprWrData,
  input  wire logic        privTrap,
  input  wire logic        illegalInsn,
  input  wire logic        insnDone
);
  logic [31:0] cGprData;
  logic [63:0] cFprData;
  logic [4:0]  cGprIdx;
  logic        cGprEn;
  logic        cTrap;
  logic        cIll;
  logic        cDone;
  initial begin
    insnValid = 1'b0;
    {insnWord, gprSrcData, gprMaskData, gprOldData} = '0;
  end
  // Calling this twice in a row issues back to back
  task automatic issue(input logic [31:0] w, s, m, o);
    @(posedge ref_clk);
    insnValid <= 1'b1;
    {insnWord, gprSrcData, gprMaskData, gprOldData} <= {w, s, m, o};
  endtask
  task automatic finish;
    @(posedge ref_clk);
    insnValid <= 1'b0;
    {insnWord, gprSrcData, gprMaskData, gprOldData} <=
      ~{insnWord, gprSrcData, gprMaskData, gprOldData};
    #1;
    {cGprEn, cGprIdx, cGprData, cFprData} = {gprWrEn, gprWrIdx, gprWrData, fprWrData};
    {cTrap, cIll, cDone} = {privTrap, illegalInsn, insnDone};
  endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the status move unit
// Assumes: Register window answers without wait states
// Notes:   Expected values are worked out by hand from the field layout
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cond_status_pkg::*;
  localparam logic [31:0] Z = 32'h0;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, insnWord, gprSrcData, gprMaskData, gprOldData, gprWrData;
  logic        hready, hreadyout, hresp, insnValid, gprWrEn, fprWrEn;
  logic        privTrap, illegalInsn, insnDone;
  logic [4:0]  gprWrIdx, fprWrIdx;
  logic [63:0] fprWrData;
  int          n_mismatch = 0;
  int          compares = 0;
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  cond_status_move_unit DUT (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .insnValid, .insnWord, .gprSrcData,
    .gprMaskData, .gprOldData, .gprWrEn, .gprWrIdx, .gprWrData, .fprWrEn, .fprWrIdx,
    .fprWrData, .privTrap, .illegalInsn, .insnDone);
  pipe_model PIPE (.ref_clk, .insnValid, .insnWord, .gprSrcData, .gprMaskData, .gprOldData,
    .gprWrEn, .gprWrIdx, .gprWrData, .fprWrData, .privTrap, .illegalInsn, .insnDone);
  task automatic complete_run;
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tally(input bit bad, input logic [63:0] got, exp);
    compares++;
    if (bad) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic got, exp);
    tally(got !== exp, {63'h0, got}, {63'h0, exp});
  endtask
  task automatic chkW(input logic [31:0] got, exp);
    tally(got !== exp, {Z, got}, {Z, exp});
  endtask
  task automatic chkF(input logic [63:0] got, exp);
    tally(got !== exp, got, exp);
  endtask
  // A bus that never answers ends the run here
  task automatic waitRdy;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
    waitRdy;
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    waitRdy;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, Z);
    chkW(rd, e);
  endtask
  function automatic logic [31:0] ins(logic [5:0] p, logic [4:0] t, logic [4:0] a,
                                      logic [9:0] x, logic r);
    return {p, t, a, 5'h0, x, r};
  endfunction
  task automatic run(input logic [31:0] w, s, m, o);
    PIPE.issue(w, s, m, o);
    PIPE.finish;
    chkB(PIPE.cDone, 1'b1);
  endtask
  task automatic resetVals;
    wr(8'h40, 32'hffffffff);
    rdc(8'h40, Z);
    rdc(OFS_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) rdc(8'(4 * i), Z);
  endtask
  task automatic copyField;
    wr(OFS_CR, 32'h01234567);
    wr(OFS_XER, 32'hf00000a5);
    PIPE.issue(ins(6'h13, 5'h08, 5'h0c, 10'h000, 1'b0), Z, Z, Z);
    run(ins(6'h13, 5'h1c, 5'h00, 10'h000, 1'b0), Z, Z, Z);
    chkB(PIPE.cGprEn, 1'b0);
    rdc(OFS_CR, 32'h01334560);
    rdc(OFS_XER, 32'hf00000a5);
  endtask
  task automatic xerCopy;
    wr(OFS_XER, 32'he00000a5);
    run(ins(6'h1f, 5'h10, 5'h00, 10'h200, 1'b0), Z, Z, Z);
    rdc(OFS_CR, 32'h0133e560);
    rdc(OFS_XER, 32'h000000a5);
  endtask
  task automatic statusCopy;
    wr(OFS_CR, Z);
    wr(OFS_FSTAT, 32'hffffffff);
    run(ins(6'h3f, 5'h18, 5'h14, 10'h040, 1'b0), Z, Z, Z);
    for (int i = 0; i < 4; i++) run(ins(6'h3f, 5'(4 * i), 5'(4 * i), 10'h040, 1'b0), Z, Z, Z);
    rdc(OFS_CR, 32'hffff0070);
    rdc(OFS_FSTAT, 32'h6007ffff);
  endtask
  task automatic reads;
    wr(OFS_CR, 32'h4055f605);
    wr(OFS_FSTAT, 32'ha5c30000);
    run(ins(6'h1f, 5'h06, 5'h00, 10'h013, 1'b0), Z, Z, Z);
    chkW(PIPE.cGprData, 32'h4055f605);
    chkW(32'(PIPE.cGprIdx), 32'h6);
    run(ins(6'h3f, 5'h0e, 5'h00, 10'h247, 1'b0), Z, Z, Z);
    chkF(PIPE.cFprData, 64'hffffffff_a5c30000);
    chkB(fprWrEn, 1'b1);
    chkW(32'(fprWrIdx), 32'he);
    rdc(OFS_CR, 32'h4055f605);
    run(ins(6'h3f, 5'h0e, 5'h00, 10'h247, 1'b1), Z, Z, Z);
    rdc(OFS_CR, 32'h4a55f605);
    rdc(OFS_FSTAT, 32'ha5c30000);
    rdc(OFS_XER, 32'h000000a5);
  endtask
  task automatic machineRead;
    logic [31:0] w;
    w = ins(6'h1f, 5'h04, 5'h00, 10'h053, 1'b0);
    wr(OFS_MSR, 32'h00001234);
    run(w, Z, Z, Z);
    chkW(PIPE.cGprData, 32'h00001234);
    wr(OFS_MSR, 32'h00005234);
    run(w, Z, Z, Z);
    chkB(PIPE.cTrap, 1'b1);
    chkB(PIPE.cGprEn, 1'b0);
    wr(OFS_CTRL, Z);
    run(w, Z, Z, Z);
    chkW(PIPE.cGprData, 32'h00005234);
    rdc(OFS_CR, 32'h4a55f605);
    rdc(OFS_XER, 32'h000000a5);
  endtask
  task automatic maskInsert;
    logic [31:0] w;
    w = ins(6'h1f, 5'h05, 5'h06, 10'h21d, 1'b0);
    run(w, 32'h55555555, 32'h000f0f00, 32'haaaaaaaa);
    chkW(PIPE.cGprData, 32'haaa5a5aa);
    chkW(32'(PIPE.cGprIdx), 32'h6);
    run(w, 32'h55555555, 32'h0a050f00, 32'haaaaaaaa);
    chkW(PIPE.cGprData, 32'ha0afa5aa);
  endtask
  task automatic foreignWords;
    run(Z, Z, Z, Z);
    chkB(PIPE.cIll, 1'b1);
    run(ins(6'h13, 5'h00, 5'h04, 10'h001, 1'b0), Z, Z, Z);
    rdc(OFS_CR, 32'h4a55f605);
    rdc(OFS_STATUS, 32'h00120002);
    wr(OFS_STATUS, Z);
    rdc(OFS_STATUS, Z);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    resetVals;
    copyField;
    xerCopy;
    statusCopy;
    reads;
    machineRead;
    maskInsert;
    foreignWords;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    complete_run;
  end
endmodule
`default_nettype wire
